// >>> pcfd_pkg.sv
package pcfd_pkg;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int CODE_W = 12;
   localparam int EQ_W = 3;
   localparam int CHN = 12;
   localparam int AW = 8;
   localparam int DW = 32;

   // ----------------------------------------------------------------
   // function codes (octal values as hex)
   // ----------------------------------------------------------------
   localparam logic [11:0] FC_RELEASE = 12'h000;
   localparam logic [11:0] FC_SINGLE = 12'h001;
   localparam logic [11:0] FC_DOUBLE = 12'h002;
   localparam logic [11:0] FC_LAST = 12'h003;
   localparam logic [11:0] FC_EJECT = 12'h004;
   localparam logic [11:0] FC_AUTO = 12'h005;
   localparam logic [11:0] FC_SUPPR = 12'h006;
   localparam logic [11:0] FC_SEL_RNB = 12'h010;
   localparam logic [11:0] FC_CLR_RNB = 12'h011;
   localparam logic [11:0] FC_SEL_EOP = 12'h012;
   localparam logic [11:0] FC_CLR_EOP = 12'h013;
   localparam logic [11:0] FC_SEL_ABN = 12'h014;
   localparam logic [11:0] FC_CLR_ABN = 12'h015;
   localparam logic [11:0] FC_POST_MODE = 12'h018;
   localparam logic [11:0] FC_POST1 = 12'h019;
   localparam logic [11:0] FC_POST12 = 12'h024;
   localparam logic [11:0] FC_PRE_MODE = 12'h028;
   localparam logic [11:0] FC_PRE1 = 12'h029;
   localparam logic [11:0] FC_PRE12 = 12'h034;
   localparam logic [8:0] CONNECT_LOW = 9'h000;
   localparam logic [3:0] CH_FIRST = 4'h0;
   localparam logic [3:0] CH_LAST = 4'hb;

   // ----------------------------------------------------------------
   // printer input vector positions
   // ----------------------------------------------------------------
   localparam int IN_EQ = 0;
   localparam int IN_HOLE = 3;
   localparam int IN_READY = 15;
   localparam int IN_BUSY = 16;
   localparam int IN_STEP = 17;
   localparam int IN_PDONE = 18;
   localparam int IN_LOAD = 19;
   localparam int IN_CHAIN = 20;
   localparam int IN_ILL = 21;
   localparam int IN_W = 22;

   // ----------------------------------------------------------------
   // apb map
   // ----------------------------------------------------------------
   localparam logic [AW-1:0] REG_CTRL = 8'h00;
   localparam logic [AW-1:0] REG_STAT = 8'h04;
   localparam int CTRL_MCLR = 0;

   typedef enum logic [1:0] {MV_IDLE, MV_LINES, MV_SKIP} pcfd_mv_type;

   // control state; all zero is the cleared state
   typedef struct packed {
      logic conn;
      logic lamp;
      logic prog_err;
      logic pre_mode;
      logic auto_ej;
      logic suppr;
      logic [3:0] post_sel;
      pcfd_mv_type mv;
      logic mv_post;
      logic [1:0] lines;
      logic [3:0] target;
      logic reload;
      logic at_last;
      logic wait_print;
      logic sel_rnb;
      logic irq_rnb;
      logic sel_eop;
      logic irq_eop;
      logic adv;
   } pcfd_ctl_type;

   typedef struct packed {
      logic [IN_W-1:0] s1;
      logic [IN_W-1:0] s2;
      logic [IN_W-1:0] s3;
      pcfd_ctl_type c;
      logic reply;
      logic reject;
      logic perr_p;
      logic pready;
      logic pslverr;
      logic [DW-1:0] prdata;
   } pcfd_st_type;

endpackage

// >>> pcfd_decoder.sv
// Contract
// - connect instruction carries equipment digit in top three bits, low nine zero
// - connect and reply only on matching equipment number and good parity
// - connect code with parity error drops an existing connection
// - unconnected controller ignores functions, writes and status requests; APB clear writes and status reads are served while unconnected
// - function code arrives as twelve parallel data lines
// - operating codes need ready and not busy; others accepted while connected
// - one code at a time; parity first, then reply if legal and doable
// - undefined or impossible codes get reject
// - parity error skips function, signals computer, lights red lamp
// - release replies and clears connection, interrupts, parity and program errors
// - 0001 spaces one line, 0002 spaces two lines
// - 0003 skips to channel 12, keeps postprint selection, self-clears
// - 0004 skips to channel 1, keeps postprint selection, self-clears
// - 0005 arms eject; motion beyond channel 12 continues to channel 1
// - 0006 cancels only the next postprint spacing
// - with 0020 selected, interrupt when ready and not busy
// - ready interrupt holds until 0020, 0021, 0000 or clear
// - 0021 replies and removes ready selection and interrupt
// - with 0022, interrupt at end of preprint motion or after reloaded print
// - end interrupt holds until 0022, 0023, 0000 or clear
// - postprint 0030-0044 and preprint 0050-0064 are legal channel codes
// - 0030 sets postprint mode, clears postprint selection, eject and suppress
// - postprint selection spaces after each print to its channel, then clears
// - 0050 enters preprint mode, no motion, no automatic single space
// - preprint selection starts motion at once to its channel
`timescale 1ns/1ps
module pcfd_decoder
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pcfd_pkg::AW-1:0] paddr,
   input wire logic [pcfd_pkg::DW-1:0] pwdata,
   output logic [pcfd_pkg::DW-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic chan_connect,
   input wire logic chan_function,
   input wire logic chan_clear,
   input wire logic [pcfd_pkg::CODE_W-1:0] chan_code,
   input wire logic chan_parity,
   output logic reply,
   output logic reject,
   output logic parity_error,
   input wire logic [pcfd_pkg::EQ_W-1:0] eq_switch,
   input wire logic printer_ready,
   input wire logic printer_busy,
   input wire logic [pcfd_pkg::CHN-1:0] tape_hole,
   input wire logic line_step,
   input wire logic print_done,
   input wire logic buffer_load,
   input wire logic chain_active,
   input wire logic illegal_char,
   output logic connected,
   output logic paper_advance,
   output logic parity_lamp,
   output logic program_error,
   output logic irq_ready,
   output logic irq_eop
);
   import pcfd_pkg::*;

   pcfd_st_type st;
   pcfd_st_type next_st;
   logic [IN_W-1:0] pins;
   logic [CHN-1:0] holes;
   logic [EQ_W-1:0] eq;
   logic rdy, bsy, load, chain, step_e, pdone_e, ill_e;
   logic rnb, par_ok, fn, apb_clr, clr, clr_rnb, clr_eop;
   logic is_post, is_pre;
   logic [DW-1:0] stat;

   // ----------------------------------------------------------------
   // printer side inputs, two flops before use
   // ----------------------------------------------------------------
   assign pins = {illegal_char, chain_active, buffer_load, print_done, line_step,
                  printer_busy, printer_ready, tape_hole, eq_switch};
   assign holes = st.s2[IN_HOLE +: CHN];
   assign eq = st.s2[IN_EQ +: EQ_W];
   assign rdy = st.s2[IN_READY];
   assign bsy = st.s2[IN_BUSY];
   assign load = st.s2[IN_LOAD];
   assign chain = st.s2[IN_CHAIN];
   assign step_e = st.s2[IN_STEP] & ~st.s3[IN_STEP];
   assign pdone_e = st.s2[IN_PDONE] & ~st.s3[IN_PDONE];
   assign ill_e = st.s2[IN_ILL] & ~st.s3[IN_ILL];

   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------
   // own motion counts as busy, so an operating code never lands mid-skip
   assign rnb = rdy & ~bsy & (st.c.mv == MV_IDLE);
   assign par_ok = ^{chan_code, chan_parity}; // odd parity over 13 lines
   assign fn = chan_function & ~chan_connect & st.c.conn;
   assign apb_clr = psel & penable & st.pready & pwrite & ~st.pslverr
                    & (paddr == REG_CTRL) & pwdata[CTRL_MCLR];
   assign clr = chan_clear | apb_clr;
   assign clr_rnb = fn & par_ok & ((chan_code == FC_RELEASE)
                    | (chan_code == FC_SEL_RNB) | (chan_code == FC_CLR_RNB));
   assign clr_eop = fn & par_ok & ((chan_code == FC_RELEASE)
                    | (chan_code == FC_SEL_EOP) | (chan_code == FC_CLR_EOP));
   assign is_post = (chan_code >= FC_POST1) && (chan_code <= FC_POST12);
   assign is_pre = (chan_code >= FC_PRE1) && (chan_code <= FC_PRE12);
   assign stat = {16'h0000, st.c.wait_print, st.c.irq_eop, st.c.sel_eop,
                  st.c.irq_rnb, st.c.sel_rnb, st.c.adv, st.c.post_sel,
                  st.c.suppr, st.c.auto_ej, st.c.pre_mode, st.c.prog_err,
                  st.c.lamp, st.c.conn};

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      next_st = st;
      next_st.s1 = pins;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      next_st.reply = 1'b0;
      next_st.reject = 1'b0;
      next_st.perr_p = 1'b0;
      next_st.pready = 1'b0;
      next_st.pslverr = 1'b0;

      // connect instruction
      if (chan_connect)
      begin
         if (!par_ok)
         begin
            next_st.perr_p = 1'b1;
            next_st.c.lamp = 1'b1;
            next_st.c.conn = 1'b0;
         end
         else if (chan_code[11:9] == eq && chan_code[8:0] == CONNECT_LOW)
         begin
            next_st.c.conn = 1'b1;
            next_st.reply = 1'b1;
         end
      end
      // function instruction, parity checked before anything else
      else if (fn)
      begin
         if (!par_ok)
         begin
            next_st.perr_p = 1'b1;
            next_st.c.lamp = 1'b1;
         end
         else
         begin
            next_st.reply = 1'b1;
            if (chan_code == FC_RELEASE)
            begin
               next_st.c.conn = 1'b0;
               next_st.c.sel_rnb = 1'b0;
               next_st.c.irq_rnb = 1'b0;
               next_st.c.sel_eop = 1'b0;
               next_st.c.irq_eop = 1'b0;
               next_st.c.wait_print = 1'b0;
               next_st.c.lamp = 1'b0;
               next_st.c.prog_err = 1'b0;
            end
            else if (chan_code == FC_SINGLE || chan_code == FC_DOUBLE
                     || chan_code == FC_LAST || chan_code == FC_EJECT || is_pre)
            begin
               if (!rnb)
               begin
                  next_st.reply = 1'b0;
                  next_st.reject = 1'b1;
               end
               else
               begin
                  next_st.c.mv_post = 1'b0;
                  next_st.c.reload = 1'b0;
                  next_st.c.mv = MV_SKIP;
                  if (chan_code == FC_SINGLE)
                  begin
                     next_st.c.mv = MV_LINES;
                     next_st.c.lines = 2'd1;
                  end
                  else if (chan_code == FC_DOUBLE)
                  begin
                     next_st.c.mv = MV_LINES;
                     next_st.c.lines = 2'd2;
                  end
                  else if (chan_code == FC_LAST)
                     next_st.c.target = CH_LAST;
                  else if (chan_code == FC_EJECT)
                     next_st.c.target = CH_FIRST;
                  else
                  begin
                     next_st.c.target = 4'(chan_code - FC_PRE1);
                     next_st.c.pre_mode = 1'b1;
                  end
               end
            end
            else if (chan_code == FC_AUTO)
               next_st.c.auto_ej = 1'b1;
            else if (chan_code == FC_SUPPR)
               next_st.c.suppr = 1'b1;
            else if (chan_code == FC_SEL_RNB)
            begin
               next_st.c.sel_rnb = 1'b1;
               next_st.c.irq_rnb = 1'b0;
            end
            else if (chan_code == FC_CLR_RNB)
            begin
               next_st.c.sel_rnb = 1'b0;
               next_st.c.irq_rnb = 1'b0;
            end
            else if (chan_code == FC_SEL_EOP)
            begin
               next_st.c.sel_eop = 1'b1;
               next_st.c.irq_eop = 1'b0;
            end
            else if (chan_code == FC_CLR_EOP)
            begin
               next_st.c.sel_eop = 1'b0;
               next_st.c.irq_eop = 1'b0;
            end
            else if (chan_code == FC_SEL_ABN || chan_code == FC_CLR_ABN)
               next_st.reply = 1'b1; // legal, no abnormal-end logic here
            else if (chan_code == FC_POST_MODE)
            begin
               next_st.c.pre_mode = 1'b0;
               next_st.c.post_sel = 4'h0;
               next_st.c.auto_ej = 1'b0;
               next_st.c.suppr = 1'b0;
            end
            else if (is_post)
            begin
               next_st.c.pre_mode = 1'b0;
               next_st.c.post_sel = 4'(chan_code - FC_POST_MODE);
            end
            else if (chan_code == FC_PRE_MODE)
               next_st.c.pre_mode = 1'b1;
            else
            begin
               next_st.reply = 1'b0;
               next_st.reject = 1'b1;
            end
         end
      end

      // postprint spacing after each printed line
      if (pdone_e)
      begin
         if (st.c.wait_print && !chain)
         begin
            next_st.c.wait_print = 1'b0;
            if (st.c.sel_eop && !clr_eop)
               next_st.c.irq_eop = 1'b1;
         end
         if (!next_st.c.pre_mode)
         begin
            if (st.c.suppr)
               next_st.c.suppr = 1'b0;
            else if (next_st.c.mv == MV_IDLE)
            begin
               next_st.c.mv_post = 1'b1;
               if (st.c.post_sel != 4'h0)
               begin
                  next_st.c.mv = MV_SKIP;
                  next_st.c.target = st.c.post_sel - 4'h1;
               end
               else
               begin
                  next_st.c.mv = MV_LINES;
                  next_st.c.lines = 2'd1;
               end
            end
         end
      end

      // paper motion, one tape line per step
      if (st.c.mv != MV_IDLE)
      begin
         if (load)
            next_st.c.reload = 1'b1;
         if (step_e)
         begin
            next_st.c.at_last = holes[CH_LAST];
            if (st.c.auto_ej && st.c.at_last)
            begin
               next_st.c.auto_ej = 1'b0;
               next_st.c.mv = MV_SKIP;
               next_st.c.target = CH_FIRST;
            end
            else if ((st.c.mv == MV_LINES && st.c.lines == 2'd1)
                     || (st.c.mv == MV_SKIP && holes[st.c.target]))
            begin
               next_st.c.mv = MV_IDLE;
               if (st.c.mv_post)
                  next_st.c.post_sel = 4'h0;
               else if (st.c.reload || load)
                  next_st.c.wait_print = 1'b1;
               else if (st.c.sel_eop && !clr_eop)
                  next_st.c.irq_eop = 1'b1;
            end
            else if (st.c.mv == MV_LINES)
               next_st.c.lines = st.c.lines - 2'd1;
         end
      end

      // ready interrupt; a clearing code wins in its own cycle
      if (st.c.sel_rnb && rnb && !clr_rnb)
         next_st.c.irq_rnb = 1'b1;
      if (ill_e)
         next_st.c.prog_err = 1'b1;

      // master or channel clear
      if (clr)
      begin
         next_st.c = '0;
         next_st.reply = 1'b0;
         next_st.reject = 1'b0;
         next_st.perr_p = 1'b0;
      end
      next_st.c.adv = (next_st.c.mv != MV_IDLE);

      // apb slave, answers in the first access cycle
      if (psel && !penable && !st.pready)
      begin
         next_st.pready = 1'b1;
         next_st.prdata = '0;
         if (paddr == REG_STAT)
            next_st.prdata = stat;
         else if (paddr != REG_CTRL)
            next_st.pslverr = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         st <= '0;
      else
         st <= next_st;
   end

   assign prdata = st.prdata;
   assign pready = st.pready;
   assign pslverr = st.pslverr;
   assign reply = st.reply;
   assign reject = st.reject;
   assign parity_error = st.perr_p;
   assign connected = st.c.conn;
   assign paper_advance = st.c.adv;
   assign parity_lamp = st.c.lamp;
   assign program_error = st.c.prog_err;
   assign irq_ready = st.c.irq_rnb;
   assign irq_eop = st.c.irq_eop;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_fn_ok(logic [11:0] c);
      fn && par_ok && chan_code == c && !clr;
   endsequence

   AST_CONN_REPLY: assert property (chan_connect && par_ok && !clr
      && chan_code[11:9] == eq && chan_code[8:0] == CONNECT_LOW |=> reply && connected)
      else $error("matching connect not replied");
   AST_CONN_DROP: assert property (chan_connect && !par_ok && !clr
      |=> parity_error && !connected && !reply)
      else $error("bad connect parity kept connection");
   AST_IGNORE: assert property (chan_function && !chan_connect && !connected && !clr
      |=> !reply && !reject && !parity_error && $stable(st.c.sel_rnb) && $stable(st.c.sel_eop))
      else $error("unconnected controller answered");
   AST_OPER_REJ: assert property (s_fn_ok(FC_SINGLE) ##0 !rnb && !paper_advance
      && !pdone_e |=> reject && !reply && !paper_advance)
      else $error("operating code taken while busy");
   AST_ONE_ANSWER: assert property ($onehot0({reply, reject, parity_error}))
      else $error("more than one answer");
   AST_UNDEF: assert property (s_fn_ok(12'h007) |=> reject && !reply)
      else $error("undefined code not rejected");
   AST_PERR: assert property (fn && !par_ok && !clr
      |=> parity_error && parity_lamp && !reply && !reject)
      else $error("function parity error not flagged");
   AST_RELEASE: assert property (s_fn_ok(FC_RELEASE)
      |=> reply && !connected && !irq_ready && !irq_eop && !parity_lamp)
      else $error("release left state behind");
   AST_DOUBLE: assert property (s_fn_ok(FC_DOUBLE) ##0 rnb
      |=> paper_advance && st.c.lines == 2'd2 ##1 paper_advance)
      else $error("double space not started");
   AST_RNB_HOLD: assert property (irq_ready && !clr_rnb && !clr |=> irq_ready)
      else $error("ready interrupt dropped by itself");

endmodule

// >>> pcfd_chan_model.sv
`timescale 1ns/1ps
module pcfd_chan_model
(
   input wire logic pclk,
   output logic chan_connect,
   output logic chan_function,
   output logic chan_clear,
   output logic [pcfd_pkg::CODE_W-1:0] chan_code,
   output logic chan_parity,
   input wire logic reply,
   input wire logic reject,
   input wire logic parity_error
);
   import pcfd_pkg::*;

   // ---------------------------------------------------------------
   // channel side of the controller
   // ---------------------------------------------------------------
   // idle lines at time zero
   initial
   begin
      chan_connect = 1'b0;
      chan_function = 1'b0;
      chan_clear = 1'b0;
      chan_code = 12'h000;
      chan_parity = 1'b0;
   end

   // one instruction for one edge; answer read in the following cycle
   task automatic send(input logic conn, input logic [CODE_W-1:0] code, input logic bad,
                       output logic [2:0] resp);
      @(posedge pclk);
      chan_connect <= conn;
      chan_function <= !conn;
      chan_code <= code;
      chan_parity <= (~^code) ^ bad; // odd over 13 lines unless bad
      @(posedge pclk);
      chan_connect <= 1'b0;
      chan_function <= 1'b0;
      chan_code <= ~code; // released lines must not keep the old value
      @(posedge pclk);
      resp = {reply, reject, parity_error};
   endtask

   // clear channel pulse
   task automatic clr;
      @(posedge pclk);
      chan_clear <= 1'b1;
      @(posedge pclk);
      chan_clear <= 1'b0;
   endtask
endmodule

// >>> printer_channel_function_decoder_tb.sv
`timescale 1ns/1ps
module printer_channel_function_decoder_tb;
   import pcfd_pkg::*;

   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   localparam logic [2:0] RP = 3'b100;
   localparam logic [2:0] RJ = 3'b010;
   localparam logic [2:0] PE = 3'b001;
   localparam logic [2:0] NO = 3'b000;
   localparam logic [2:0] EQ = 3'h5;
   localparam logic [11:0] CN = {EQ, CONNECT_LOW};
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic chan_connect, chan_function, chan_clear, chan_parity;
   logic [11:0] chan_code, tape_hole;
   logic reply, reject, parity_error, printer_ready, printer_busy, line_step;
   logic print_done, buffer_load, chain_active, illegal_char, connected;
   logic paper_advance, parity_lamp, program_error, irq_ready, irq_eop, er;
   logic [2:0] eq_switch, r;
   int err_total = 0;
   int n_tests = 0;

   pcfd_decoder pcfd_decoder_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .chan_connect(chan_connect), .chan_function(chan_function),
      .chan_clear(chan_clear), .chan_code(chan_code), .chan_parity(chan_parity),
      .reply(reply), .reject(reject), .parity_error(parity_error),
      .eq_switch(eq_switch), .printer_ready(printer_ready),
      .printer_busy(printer_busy), .tape_hole(tape_hole), .line_step(line_step),
      .print_done(print_done), .buffer_load(buffer_load),
      .chain_active(chain_active), .illegal_char(illegal_char),
      .connected(connected), .paper_advance(paper_advance),
      .parity_lamp(parity_lamp), .program_error(program_error),
      .irq_ready(irq_ready), .irq_eop(irq_eop));

   pcfd_chan_model pcfd_chan_model_i (.pclk(pclk), .chan_connect(chan_connect),
      .chan_function(chan_function), .chan_clear(chan_clear),
      .chan_code(chan_code), .chan_parity(chan_parity), .reply(reply),
      .reject(reject), .parity_error(parity_error));

   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         err_total++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic fn(input logic [11:0] c, input logic [2:0] e);
      pcfd_chan_model_i.send(1'b0, c, 1'b0, r);
      chk(r, e);
   endtask

   task automatic cn(input logic [11:0] c, input logic bad, input logic [2:0] e);
      pcfd_chan_model_i.send(1'b1, c, bad, r);
      chk(r, e);
   endtask

   // one paper line; wait covers the input synchronisers
   task automatic step(input logic [11:0] h);
      tape_hole <= h;
      line_step <= 1'b1;
      wt(4);
      line_step <= 1'b0;
      wt(4);
   endtask

   // one printed line, pulse held past the synchronisers
   task automatic prt;
      print_done <= 1'b1;
      wt(4);
      print_done <= 1'b0;
      wt(4);
   endtask

   // apb transfer, held until pready is seen
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // clock, watchdog, tests
   // ---------------------------------------------------------------
   // free running 40 MHz clock
   always #12.5 pclk = ~pclk;

   // cut a hang short well beyond the expected run
   initial
   begin
      wt(20000);
      err_total++;
      give_verdict;
   end

   // main sequence
   initial
   begin
      pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 8'h00; pwdata = 32'h0; eq_switch = EQ; printer_ready = 1'b0;
      printer_busy = 1'b0; tape_hole = 12'h000; line_step = 1'b0; print_done = 1'b0;
      buffer_load = 1'b0; chain_active = 1'b0; illegal_char = 1'b0;
      wt(10);
      presetn <= 1'b1;
      wt(4);
      fn(FC_SINGLE, NO);
      cn({3'h2, CONNECT_LOW}, 1'b0, NO);
      chk(connected, 0);
      cn(CN, 1'b0, RP);
      chk(connected, 1);
      pcfd_chan_model_i.send(1'b0, FC_SINGLE, 1'b1, r);
      chk(r, PE);
      chk(parity_lamp, 1);
      fn(12'h007, RJ);
      fn(12'h016, RJ);
      fn(FC_POST12 + 12'h001, RJ);
      fn(FC_PRE12 + 12'h001, RJ);
      fn(FC_SINGLE, RJ);
      printer_ready <= 1'b1;
      wt(4);
      fn(FC_SINGLE, RP);
      chk(paper_advance, 1);
      step(12'h000);
      chk(paper_advance, 0);
      fn(FC_DOUBLE, RP);
      step(12'h000);
      chk(paper_advance, 1);
      step(12'h000);
      chk(paper_advance, 0);
      fn(FC_LAST, RP);
      step(12'h000);
      chk(paper_advance, 1);
      step(12'h800);
      chk(paper_advance, 0);
      fn(FC_AUTO, RP);
      fn(FC_SINGLE, RP);
      step(12'h000);
      chk(paper_advance, 1);
      step(12'h001);
      chk(paper_advance, 0);
      fn(FC_EJECT, RP);
      step(12'h000);
      chk(paper_advance, 1);
      step(12'h001);
      chk(paper_advance, 0);
      printer_busy <= 1'b1;
      wt(4);
      fn(FC_EJECT, RJ);
      fn(FC_SUPPR, RP);
      fn(FC_SEL_EOP, RP);
      fn(FC_CLR_EOP, RP);
      fn(FC_SEL_ABN, RP);
      fn(FC_CLR_ABN, RP);
      printer_busy <= 1'b0;
      wt(4);
      for (int k = 0; k < 12; k++)
         fn(FC_POST1 + 12'(k), RP);
      fn(FC_POST_MODE, RP);
      fn(FC_PRE_MODE, RP);
      wt(2);
      chk(paper_advance, 0);
      fn(FC_PRE1 + 12'h002, RP);
      chk(paper_advance, 1);
      step(12'h004);
      chk(paper_advance, 0);
      fn(FC_SEL_RNB, RP);
      wt(3);
      chk(irq_ready, 1);
      fn(FC_CLR_RNB, RP);
      chk(irq_ready, 0);
      illegal_char <= 1'b1;
      wt(4);
      illegal_char <= 1'b0;
      fn(FC_SEL_RNB, RP);
      wt(3);
      chk({program_error, irq_ready}, 3);
      fn(FC_RELEASE, RP);
      wt(1);
      chk({connected, parity_lamp, program_error, irq_ready}, 0);
      fn(FC_SINGLE, NO);
      cn(CN, 1'b0, RP);
      cn(CN, 1'b1, PE);
      chk(connected, 0);
      cn(CN, 1'b0, RP);
      fn(FC_PRE_MODE, RP);
      fn(FC_SEL_EOP, RP);
      fn(FC_SINGLE, RP);
      step(12'h000);
      chk(irq_eop, 1);
      fn(FC_SEL_EOP, RP);
      chk(irq_eop, 0);
      buffer_load <= 1'b1;
      fn(FC_SINGLE, RP);
      step(12'h000);
      buffer_load <= 1'b0;
      chain_active <= 1'b1;
      chk(irq_eop, 0);
      prt;
      chk({irq_eop, paper_advance}, 0);
      chain_active <= 1'b0;
      prt;
      chk(irq_eop, 1);
      fn(FC_CLR_EOP, RP);
      chk(irq_eop, 0);
      fn(FC_POST1 + 12'h001, RP);
      prt;
      step(12'h000);
      chk(paper_advance, 1);
      step(12'h002);
      chk(paper_advance, 0);
      prt;
      chk(paper_advance, 1);
      step(12'h000);
      chk(paper_advance, 0);
      fn(FC_SUPPR, RP);
      prt;
      chk(paper_advance, 0);
      prt;
      chk(paper_advance, 1);
      step(12'h000);
      fn(FC_SEL_RNB, RP);
      wt(3);
      apb(1'b0, REG_STAT, 32'h0);
      chk(rd & 32'h1801, 32'h1801);
      apb(1'b1, REG_CTRL, 32'h1);
      apb(1'b0, REG_STAT, 32'h0);
      chk(rd, 0);
      apb(1'b0, 8'h08, 32'h0);
      chk(er, 1);
      chk(rd, 0);
      cn(CN, 1'b0, RP);
      fn(FC_SEL_RNB, RP);
      pcfd_chan_model_i.clr();
      wt(2);
      chk({connected, irq_ready}, 0);
      give_verdict;
   end
endmodule
